// >>> design/sepc_core.sv
// Serial EEPROM slave: link shifter, command decode, protection and array
//
// Function
// - Status writes refused when pin low and enable set
// - Running status write finishes; later attempts refused
// - Pin high: all writes behave normally
// - Enable bit clear: protect pin ignored
// - Read: opcode, 16-bit address, then data out
// - Read address advances after each byte
// - Read address wraps to zero past top
// - Chip select rise ends read, stops output
// - Read-status opcode shifts status byte out
// - Write-enable only if select rises after eight bits
// - Write data wraps within the same page
// - Write starts only on whole-byte select rise
// - Busy bit high during write, status readable
// - Standby until synchronised chip select is seen high after power-up
// - Power-up: output off, latch and flag cleared
// - Opcodes decoded most significant bit first
// - Status byte bit order as documented
// - Write-enable latch clears after finished write
// - Sample on rising, drive on falling edge
module sepc_core #(
  parameter int ADDR_W       = sepc_pkg::ADDR_W_DEF,
  parameter int PAGE_BYTES   = sepc_pkg::PAGE_BYTES_DEF,
  parameter int WRITE_CYCLES = sepc_pkg::WRITE_CYCLES
) (
  input  wire logic                          I_CLK_SYS,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_SCK,
  input  wire logic                          I_CS_N,
  input  wire logic                          I_SI,
  input  wire logic                          I_WP_N,
  output logic                               O_SO,
  output logic                               O_SO_OE,
  output logic      [sepc_pkg::STATUS_W-1:0] O_STATUS,
  output logic                               O_BUSY
);
  import sepc_pkg::*;

  localparam int DEPTH  = 1 << ADDR_W;
  localparam int PAGE_W = $clog2(PAGE_BYTES);
  localparam int TMR_W  = $clog2(WRITE_CYCLES + 1);

  // ---------------- Link side, clocked by the serial clock ----------------
  logic                  lk_act_rst_n;
  logic                  lk_act_reg;
  logic [6:0]            lk_shift_reg;
  logic [6:0]            lk_shift_next;
  logic [2:0]            lk_bit_reg;
  logic [2:0]            lk_bit_next;
  logic [2:0]            lk_bytes_reg;
  logic [2:0]            lk_bytes_next;
  logic [7:0]            lk_op_reg;
  logic [7:0]            lk_op_next;
  logic [15:0]           lk_addr_reg;
  logic [15:0]           lk_addr_next;
  logic [ADDR_W-1:0]     lk_rd_reg;
  logic [ADDR_W-1:0]     lk_rd_next;
  logic [PAGE_W-1:0]     lk_off_reg;
  logic [PAGE_W-1:0]     lk_off_next;
  logic [7:0]            lk_buf_reg [PAGE_BYTES];
  logic [7:0]            lk_buf_next [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] lk_load_reg;
  logic [PAGE_BYTES-1:0] lk_load_next;
  logic [2:0]            cur_bit;
  logic [2:0]            cur_bytes;
  logic [7:0]            rx_byte;
  logic [15:0]           full_addr;
  logic [7:0]            st_lk;
  logic [7:0]            tx_byte;
  logic                  out_phase;
  logic                  so_reg;
  logic                  so_next;
  logic                  so_oe_reg;
  logic                  so_oe_next;

  // ---------------- System side ----------------
  sepc_state_t           state_reg;
  sepc_state_t           state_next;
  logic [TMR_W-1:0]      tmr_reg;
  logic [TMR_W-1:0]      tmr_next;
  logic                  latch_reg;
  logic                  latch_next;
  logic                  flag_reg;
  logic                  flag_next;
  logic                  pen_reg;
  logic                  pen_next;
  logic [1:0]            wd_reg;
  logic [1:0]            wd_next;
  logic [1:0]            bl_reg;
  logic [1:0]            bl_next;
  logic                  armed_reg;
  logic                  armed_next;
  logic                  cs_d_reg;
  logic [7:0]            mem_reg [DEPTH];
  logic [7:0]            mem_next [DEPTH];
  logic                  cs_s;
  logic                  wp_s;
  logic                  cs_rise;
  logic                  go;
  logic                  ok_cmd;
  logic                  ok_st;
  logic                  ok_arr;
  logic                  st_locked;
  logic                  arr_prot;
  logic                  commit_st;
  logic                  commit_arr;
  logic [1:0]            quarter;
  logic [7:0]            st_data;
  logic [ADDR_W-PAGE_W-1:0] page_base;

  // Chip select high clears the frame-active flag and the SO output registers; the rest keeps its
  // value after the frame so the system side can judge the finished frame.
  assign lk_act_rst_n = I_RST_N & ~I_CS_N;

  always_ff @(posedge I_SCK or negedge lk_act_rst_n) begin
    if (!lk_act_rst_n) begin
      lk_act_reg <= 1'b0;
    end else begin
      lk_act_reg <= 1'b1;
    end
  end

  always_comb begin
    cur_bit       = lk_act_reg ? lk_bit_reg : 3'h0;
    cur_bytes     = lk_act_reg ? lk_bytes_reg : 3'h0;
    rx_byte       = {lk_shift_reg, I_SI};
    full_addr     = {lk_addr_reg[15:8], rx_byte};
    lk_shift_next = rx_byte[6:0];
    lk_bit_next   = cur_bit + 3'h1;
    lk_bytes_next = cur_bytes;
    lk_op_next    = lk_op_reg;
    lk_addr_next  = lk_addr_reg;
    lk_rd_next    = lk_rd_reg;
    lk_off_next   = lk_off_reg;
    lk_buf_next   = lk_buf_reg;
    lk_load_next  = lk_act_reg ? lk_load_reg : '0;
    if (cur_bit == BIT_LAST) begin
      if (cur_bytes != BYTES_SAT) begin
        lk_bytes_next = cur_bytes + 3'h1;
      end
      case (cur_bytes)
        3'h0: begin
          lk_op_next = rx_byte;
        end
        3'h1: begin
          lk_addr_next[15:8] = rx_byte;
        end
        3'h2: begin
          lk_addr_next[7:0] = rx_byte;
          lk_rd_next        = full_addr[ADDR_W-1:0];
          lk_off_next       = full_addr[PAGE_W-1:0];
        end
        default: begin
          if (lk_op_reg == OP_READ) begin
            // Counter width equals the array width, so it rolls to zero
            lk_rd_next = lk_rd_reg + 1'b1;
          end
          if (lk_op_reg == OP_WRITE) begin
            lk_buf_next[lk_off_reg]  = rx_byte;
            lk_load_next[lk_off_reg] = 1'b1;
            lk_off_next              = lk_off_reg + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_SCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lk_shift_reg <= '0;
      lk_bit_reg   <= '0;
      lk_bytes_reg <= '0;
      lk_op_reg    <= '0;
      lk_addr_reg  <= '0;
      lk_rd_reg    <= '0;
      lk_off_reg   <= '0;
      lk_buf_reg   <= '{default: '0};
      lk_load_reg  <= '0;
    end else begin
      lk_shift_reg <= lk_shift_next;
      lk_bit_reg   <= lk_bit_next;
      lk_bytes_reg <= lk_bytes_next;
      lk_op_reg    <= lk_op_next;
      lk_addr_reg  <= lk_addr_next;
      lk_rd_reg    <= lk_rd_next;
      lk_off_reg   <= lk_off_next;
      lk_buf_reg   <= lk_buf_next;
      lk_load_reg  <= lk_load_next;
    end
  end

  // Status bits cross as levels; busy and latch can clear mid-frame when a write ends, the rest change only between frames
  sepc_sync #(
    .W       (8),
    .RST_VAL (8'h00)
  ) u_status_sync (
    .i_clk   (I_SCK),
    .i_rst_n (I_RST_N),
    .i_d     (O_STATUS),
    .o_q     (st_lk)
  );

  // Array is read across domains unsynchronised: it only changes at a commit,
  // which happens after the frame that wrote it has closed.
  always_comb begin
    tx_byte    = (lk_op_reg == OP_RD_ST) ? st_lk : mem_reg[lk_rd_reg];
    out_phase  = lk_act_reg &&
                 (((lk_op_reg == OP_RD_ST) && (lk_bytes_reg >= BYTES_CMD)) ||
                  ((lk_op_reg == OP_READ) && (lk_bytes_reg >= BYTES_ADDR)));
    so_next    = out_phase ? tx_byte[BIT_LAST - lk_bit_reg] : 1'b0;
    so_oe_next = out_phase;
  end

  always_ff @(negedge I_SCK or negedge lk_act_rst_n) begin
    if (!lk_act_rst_n) begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg    <= so_next;
      so_oe_reg <= so_oe_next;
    end
  end

  assign O_SO    = so_reg;
  assign O_SO_OE = so_oe_reg & armed_reg;

  // ---------------- System side ----------------
  sepc_sync #(
    .W       (2),
    .RST_VAL (2'b11)
  ) u_pin_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_d     ({I_CS_N, I_WP_N}),
    .o_q     ({cs_s, wp_s})
  );

  // Link registers are read here only after chip select rose and the serial
  // clock has stopped, so they are steady by the time the edge is seen.
  always_comb begin
    cs_rise    = cs_s & ~cs_d_reg;
    st_data    = lk_addr_reg[15:8];
    page_base  = lk_addr_reg[ADDR_W-1:PAGE_W];
    quarter    = lk_addr_reg[ADDR_W-1 -: 2];
    go         = cs_rise && armed_reg && (state_reg == SEPC_IDLE);
    ok_cmd     = (lk_bytes_reg == BYTES_CMD) && (lk_bit_reg == 3'h0);
    ok_st      = (lk_bytes_reg == BYTES_STATUS) && (lk_bit_reg == 3'h0);
    ok_arr     = (lk_bytes_reg >= BYTES_DATA) && (lk_bit_reg == 3'h0);
    st_locked  = pen_reg & ~wp_s;
    arr_prot   = (bl_reg == 2'h3) || ((bl_reg == 2'h2) && quarter[1]) ||
                 ((bl_reg == 2'h1) && (quarter == 2'h3));
    commit_st  = go && (lk_op_reg == OP_WR_ST) && ok_st && latch_reg && !st_locked;
    commit_arr = go && (lk_op_reg == OP_WRITE) && ok_arr && latch_reg && !arr_prot;

    state_next = state_reg;
    tmr_next   = tmr_reg;
    latch_next = latch_reg;
    flag_next  = flag_reg;
    pen_next   = pen_reg;
    wd_next    = wd_reg;
    bl_next    = bl_reg;
    armed_next = armed_reg | cs_s;
    mem_next   = mem_reg;

    case (state_reg)
      SEPC_IDLE: begin
        if (go && ok_cmd) begin
          case (lk_op_reg)
            OP_SET_WL: latch_next = 1'b1;
            OP_SFLAG:  flag_next  = 1'b1;
            OP_CLR_WL: begin
              latch_next = 1'b0;
              flag_next  = 1'b0;
            end
            default: latch_next = latch_reg;
          endcase
        end
        if (commit_st) begin
          // Low two data bits are left to the master to send as zero
          pen_next   = st_data[ST_PEN];
          flag_next  = st_data[ST_FLAG];
          wd_next    = st_data[ST_WD_HI:ST_WD_LO];
          bl_next    = st_data[ST_BL_HI:ST_BL_LO];
          state_next = SEPC_BUSY;
          tmr_next   = TMR_W'(WRITE_CYCLES - 1);
        end
        if (commit_arr) begin
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (lk_load_reg[i]) begin
              mem_next[{page_base, PAGE_W'(i)}] = lk_buf_reg[i];
            end
          end
          state_next = SEPC_BUSY;
          tmr_next   = TMR_W'(WRITE_CYCLES - 1);
        end
      end
      SEPC_BUSY: begin
        // A protect pin change here is not looked at until the next frame
        if (tmr_reg == '0) begin
          state_next = SEPC_IDLE;
          latch_next = 1'b0;
        end else begin
          tmr_next = tmr_reg - 1'b1;
        end
      end
      default: state_next = SEPC_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= SEPC_IDLE;
      tmr_reg   <= '0;
      latch_reg <= 1'b0;
      flag_reg  <= 1'b0;
      pen_reg   <= PEN_RST;
      wd_reg    <= WD_RST;
      bl_reg    <= BL_RST;
      armed_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
      mem_reg   <= '{default: '0};
    end else begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
      latch_reg <= latch_next;
      flag_reg  <= flag_next;
      pen_reg   <= pen_next;
      wd_reg    <= wd_next;
      bl_reg    <= bl_next;
      armed_reg <= armed_next;
      cs_d_reg  <= cs_s;
      mem_reg   <= mem_next;
    end
  end

  assign O_BUSY   = (state_reg == SEPC_BUSY);
  assign O_STATUS = {pen_reg, flag_reg, wd_reg, bl_reg, latch_reg, O_BUSY};

  // ---------------- Assertions ----------------
  default clocking cb_sys @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  status_lock_a: assert property (
    (go && (lk_op_reg == OP_WR_ST) && pen_reg && !wp_s) |=> (state_reg == SEPC_IDLE)
  ) else $error("status write accepted while locked");

  lock_finish_a: assert property (
    ((state_reg == SEPC_BUSY) && (tmr_reg != '0)) |=> (state_reg == SEPC_BUSY)
  ) else $error("write cycle cut short");

  pen_free_a: assert property (
    (go && (lk_op_reg == OP_WR_ST) && ok_st && latch_reg && !pen_reg)
      |=> (state_reg == SEPC_BUSY) && (pen_reg == $past(st_data[ST_PEN]))
  ) else $error("status write refused with enable clear");

  latch_clear_a: assert property (
    ((state_reg == SEPC_BUSY) && (tmr_reg == '0)) |=> (!latch_reg && (state_reg == SEPC_IDLE))
  ) else $error("latch not cleared after write");

  latch_exact_a: assert property (
    (go && (lk_op_reg == OP_SET_WL) && !ok_cmd && !latch_reg) |=> !latch_reg
  ) else $error("write enable set by long frame");

  page_frame_a: assert property (
    (go && (lk_op_reg == OP_WRITE) && (lk_bit_reg != 3'h0)) |=> (state_reg == SEPC_IDLE)
  ) else $error("array write started on partial byte");

  busy_hold_a: assert property (
    $rose(O_BUSY) |-> O_STATUS[ST_BUSY] [*8]
  ) else $error("busy bit dropped early");

  standby_a: assert property (
    !armed_reg |=> ((state_reg == SEPC_IDLE) && !O_SO_OE)
  ) else $error("activity before first select");

  so_quiet_a: assert property (
    (cs_s && cs_d_reg) |-> !O_SO_OE
  ) else $error("output driven with select high");

  array_write_c: cover property (commit_arr);
  status_write_c: cover property (commit_st);
  locked_refuse_c: cover property (go && (lk_op_reg == OP_WR_ST) && ok_st && latch_reg && st_locked);
  latch_take_c: cover property (go && ok_cmd && (lk_op_reg == OP_SET_WL));

endmodule

// >>> design/sepc_pkg.sv
// Shared constants and types for the serial EEPROM command and protection block
package sepc_pkg;

  // Opcodes, sent most significant bit first
  localparam logic [7:0] OP_SET_WL = 8'h06;
  localparam logic [7:0] OP_SFLAG  = 8'h00;
  localparam logic [7:0] OP_CLR_WL = 8'h04;
  localparam logic [7:0] OP_RD_ST  = 8'h05;
  localparam logic [7:0] OP_WR_ST  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // Status byte layout
  localparam int STATUS_W  = 8;
  localparam int ST_BUSY   = 0;
  localparam int ST_LATCH  = 1;
  localparam int ST_BL_LO  = 2;
  localparam int ST_BL_HI  = 3;
  localparam int ST_WD_LO  = 4;
  localparam int ST_WD_HI  = 5;
  localparam int ST_FLAG   = 6;
  localparam int ST_PEN    = 7;

  // Values after reset of the stored status fields
  localparam logic       PEN_RST  = 1'b0;
  localparam logic [1:0] WD_RST   = 2'h0;
  localparam logic [1:0] BL_RST   = 2'h0;

  // Frame lengths in whole bytes at the moment chip select rises, byte counter limit and last bit index
  localparam logic [2:0] BYTES_CMD    = 3'h1;
  localparam logic [2:0] BYTES_STATUS = 3'h2;
  localparam logic [2:0] BYTES_ADDR   = 3'h3;
  localparam logic [2:0] BYTES_DATA   = 3'h4;
  localparam logic [2:0] BYTES_SAT    = 3'h7;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  // Array geometry
  localparam int ADDR_W_DEF     = 11;
  localparam int PAGE_BYTES_DEF = 32;

  // Internal write time
  localparam int CLK_FREQ_HZ    = 40_000_000;
  localparam int WRITE_TIME_US  = 5000;
  localparam int WRITE_CYCLES   = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  typedef enum logic {SEPC_IDLE, SEPC_BUSY} sepc_state_t;

endpackage

// >>> design/sepc_sync.sv
// Two flip-flop level synchroniser, W bits wide
module sepc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = i_d;
    q_next    = meta_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule

// >>> testbench/sepc_spi_master.sv
// Behavioural SPI master that stands in for the microcontroller on the link
module sepc_spi_master (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // 32 ns link period; the clock only toggles inside frames
  localparam int HALF_NS = 16;

  logic slow;

  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
    slow   = 1'b0;
  end

  task automatic select();
    o_cs_n = 1'b0;
    #40;
  endtask

  // Released data line shows the inverse of its last bit, not a stale value
  task automatic deselect();
    #20;
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    #150;
  endtask

  // Sends nbits of tx from bit 7 down; samples SO on each rising edge
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      o_si = tx[i];
      #HALF_NS;
      o_sck = 1'b1;
      rx    = {rx[6:0], i_so};
      #HALF_NS;
      o_sck = 1'b0;
    end
    // Slow master: clock held static between bytes
    if (slow) #(10 * HALF_NS);
  endtask

  task automatic send_addr(input logic [15:0] a);
    logic [7:0] rx;
    shift(a[15:8], 8, rx);
    shift(a[7:0], 8, rx);
  endtask
endmodule

// >>> testbench/spi_eeprom_command_protect_tb_top.sv
// Self-checking bench for the serial EEPROM command and protection block
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("ERROR %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

module spi_eeprom_command_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sepc_pkg::*;

  localparam int AW    = 11;
  localparam int PB    = 32;
  localparam int WC    = 100;
  localparam int DEPTH = 1 << AW;

  logic        clk_sys;
  logic        rst_n;
  logic        wp_n;
  wire         sck;
  wire         cs_n;
  wire         si;
  logic        so;
  logic        so_oe;
  logic [7:0]  status;
  logic        busy;
  int          failures;
  int          cmp_count;
  logic [31:0] rng;
  logic [7:0]  mem [DEPTH];
  logic [7:0]  rx;
  logic [7:0]  st;
  logic [7:0]  d;
  logic [15:0] a;

  sepc_core #(
    .ADDR_W      (AW),
    .PAGE_BYTES  (PB),
    .WRITE_CYCLES(WC)
  ) u_dut (
    .I_CLK_SYS(clk_sys),
    .I_RST_N  (rst_n),
    .I_SCK    (sck),
    .I_CS_N   (cs_n),
    .I_SI     (si),
    .I_WP_N   (wp_n),
    .O_SO     (so),
    .O_SO_OE  (so_oe),
    .O_STATUS (status),
    .O_BUSY   (busy)
  );

  sepc_spi_master u_mst (
    .o_sck  (sck),
    .o_cs_n (cs_n),
    .o_si   (si),
    .i_so   (so),
    .i_so_oe(so_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic final_report();
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic op8(input logic [7:0] op);
    u_mst.select();
    u_mst.shift(op, 8, rx);
    u_mst.deselect();
  endtask

  task automatic read_status(output logic [7:0] s);
    u_mst.select();
    u_mst.shift(OP_RD_ST, 8, s);
    u_mst.shift(8'h00, 8, s);
    u_mst.deselect();
  endtask

  task automatic write_status(input logic [7:0] v);
    op8(OP_SET_WL);
    u_mst.select();
    u_mst.shift(OP_WR_ST, 8, rx);
    u_mst.shift(v, 8, rx);
    u_mst.deselect();
  endtask

  // Page write of n bytes; extra odd bits after them must cancel it
  task automatic arr_write(input logic [15:0] wa, input int n, input int extra);
    logic [7:0] v;
    int         idx;
    op8(OP_SET_WL);
    u_mst.select();
    u_mst.shift(OP_WRITE, 8, rx);
    u_mst.send_addr(wa);
    for (int i = 0; i < n; i++) begin
      v   = 8'(xs());
      idx = (int'(wa) / PB) * PB + (int'(wa) + i) % PB;
      u_mst.shift(v, 8, rx);
      if (extra == 0) mem[idx] = v;
    end
    if (extra > 0) u_mst.shift(8'(xs()), extra, rx);
    u_mst.deselect();
  endtask

  task automatic rd_check(input logic [15:0] ra, input int n);
    u_mst.slow = rng[3];
    u_mst.select();
    u_mst.shift(OP_READ, 8, rx);
    u_mst.send_addr(ra);
    for (int i = 0; i < n; i++) begin
      u_mst.shift(8'h00, 8, rx);
      `CHK(rx, mem[(int'(ra) + i) % DEPTH])
    end
    `CHK(so_oe, 1'b1)
    u_mst.deselect();
    `CHK(so_oe, 1'b0)
    u_mst.slow = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2 * WC) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n < 2 * WC, 1'b1)
  endtask

  task automatic set_wp(input logic v);
    @(negedge clk_sys);
    wp_n = v;
    repeat (4) @(negedge clk_sys);
  endtask

  // Whole run needs well under this span
  initial begin
    #1_000_000;
    failures++;
    final_report();
  end

  initial begin
    failures  = 0;
    cmp_count = 0;
    rng       = 32'h5;
    rst_n     = 1'b0;
    wp_n      = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK(status, 8'h00)
    `CHK(so_oe, 1'b0)
    read_status(st);
    `CHK(st, 8'h00)
    op8(OP_SET_WL);
    `CHK(status, 8'h02)
    op8(OP_SFLAG);
    read_status(st);
    `CHK(st, 8'h42)
    op8(OP_CLR_WL);
    `CHK(status, 8'h00)
    u_mst.select();
    u_mst.shift(OP_SET_WL, 8, rx);
    u_mst.shift(OP_WRITE, 8, rx);
    u_mst.send_addr(16'h0010);
    u_mst.shift(8'hA5, 8, rx);
    u_mst.deselect();
    `CHK(busy, 1'b0)
    `CHK(status[1], 1'b0)
    a = {5'h00, 6'(xs()), 5'h1E};
    arr_write(a, 4, 0);
    `CHK(busy, 1'b1)
    read_status(st);
    `CHK(st[1:0], 2'b11)
    wait_idle();
    `CHK(status[1:0], 2'b00)
    rd_check(a & 16'hFFE0, PB);
    arr_write(a, 2, 3);
    `CHK(busy, 1'b0)
    op8(OP_CLR_WL);
    rd_check(a & 16'hFFE0, PB);
    repeat (4) begin
      a = {5'h00, 11'(xs())};
      arr_write(a, 1 + int'(xs() % 40), 0);
      wait_idle();
      rd_check(a, 8);
    end
    rd_check(16'(DEPTH - 2), 4);
    d = {1'b1, 5'(xs()), 2'b00};
    write_status(d);
    wait_idle();
    `CHK(status, d)
    set_wp(1'b0);
    write_status(8'h00);
    wait_idle();
    `CHK(status[7:2], d[7:2])
    set_wp(1'b1);
    d = {1'b1, 5'(xs()), 2'b00};
    write_status(d);
    set_wp(1'b0);
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(status[7:2], d[7:2])
    write_status(8'h00);
    wait_idle();
    `CHK(status[7:2], d[7:2])
    set_wp(1'b1);
    write_status(8'h00);
    wait_idle();
    `CHK(status, 8'h00)
    set_wp(1'b0);
    d = {1'b0, 5'(xs()), 2'b00};
    write_status(d);
    wait_idle();
    `CHK(status, d)
    final_report();
  end
endmodule
